/* File: src/dpsa_pkg.sv */
// constants and command codes of the dual-port status arbiter
// =====================================================================
// Operation
// - owner with no pending notice reads 0x01 for port zero, 0x10 for port one.
// - command from port one while not owner is refused; byte 0xC1; only its alert.
// - command from port zero while port one owns is refused; byte 0x1C; its alert.
// - clear from non-owner clears only its own notice nibble and releases its alert if no unit status stays latched.
// - unit fault latches status word, asserts both alerts, byte unchanged.
// - port one takeover gives 0x74, keeps status word, both alerts stay asserted.
// - port zero takeover gives 0x47 and both alerts even with zero status word.
// - only owner clears unit status; its clear also drops its own notice bits.
// - alert stays while own notice bits remain; own clear releases it if no unit status stays latched.
// - port zero takeover then its clear leaves 0x41; only port one alert stays.
// - bad command from owner sets word 0x0002, comm status 0x80, owner alert.
// - listed status bits latch on set and hold until owner clear.
// - output shutdown indication latches until cleared.
// - voltage, current, input, unknown, comm and fault indications all latch.
// - isolation switch test pass or fail result latches until owner clears.
// - over-current and over-temperature responses change only by command.
// - fault still live after clear sets again; operational state never latches.
// - no separate restarted bit; latched status conveys it.
// - alert outputs are active low, open drain, pulled up outside.
// =====================================================================
package dpsa_pkg;

   // =====================================================================
   // commands delivered by each port's front end
   typedef enum logic [2:0] {
      DPSA_CMD_READ   = 3'h0,
      DPSA_CMD_WRITE  = 3'h1,
      DPSA_CMD_CLEAR  = 3'h2,
      DPSA_CMD_BAD    = 3'h3,
      DPSA_CMD_TAKE   = 3'h4,
      DPSA_CMD_SET_OC = 3'h5,
      DPSA_CMD_SET_OT = 3'h6
   } dpsa_cmd_t;

   // =====================================================================
   // ownership byte: one nibble per port, bit 0 is control
   localparam int          NIB_W       = 4;
   localparam logic [3:0]  NIB_CTL     = 4'h1;
   localparam logic [3:0]  NIB_NOTICE  = 4'hE;
   localparam logic [3:0]  NIB_TAKE    = 4'h7;
   localparam logic [3:0]  NIB_LOST    = 4'h4;
   localparam logic [3:0]  NIB_REJECT  = 4'hC;
   localparam logic [7:0]  BUS_RESET   = 8'h01;

   // =====================================================================
   // status word and comm status
   localparam int          WORD_W      = 16;
   localparam logic [15:0] WORD_CML    = 16'h0002;
   localparam logic [15:0] WORD_ZERO   = 16'h0000;
   localparam logic [7:0]  CML_BAD     = 8'h80;
   localparam logic [7:0]  BYTE_ZERO   = 8'h00;
   localparam logic [1:0]  ISO_ZERO    = 2'h0;

endpackage

/* File: src/dpsa_sync2.sv */
// two-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module dpsa_sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   // levels
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta;

   if (W < 1) begin : g_bad_width
      $error("width must be positive");
   end

   // meta feeds o_q only
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meta <= '0;
         o_q  <= '0;
      end else begin
         meta <= i_d;
         o_q  <= meta;
      end
   end
endmodule
`default_nettype wire

/* File: src/dpsa_cmd_xing.sv */
// toggle handshake carrying one port command from link to core clock
`timescale 1ns/10ps
`default_nettype none
module dpsa_cmd_xing (
   // link side
   input  wire logic       i_link_clk,
   input  wire logic       i_strobe,
   input  wire logic [2:0] i_code,
   input  wire logic [7:0] i_data,
   output logic            o_busy,
   // core side
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst,
   output logic            o_valid,
   output logic [2:0]      o_code,
   output logic [7:0]      o_data
);
   logic       rst_m, rst_l;
   logic       req, ack_m, ack_l;
   logic [2:0] hold_code;
   logic [7:0] hold_data;
   logic       req_m, req_s, req_d, ack;

   // =====================================================================
   // link domain: held words stay still until the ack returns
   always_ff @(posedge i_link_clk) begin
      rst_m <= i_rst;
      rst_l <= rst_m;
   end

   always_ff @(posedge i_link_clk) begin
      if (rst_l) begin
         req       <= 1'b0;
         ack_m     <= 1'b0;
         ack_l     <= 1'b0;
         o_busy    <= 1'b0;
         hold_code <= 3'h0;
         hold_data <= 8'h00;
      end else begin
         ack_m <= ack;
         ack_l <= ack_m;
         if (i_strobe && !o_busy) begin
            req       <= ~req;
            hold_code <= i_code;
            hold_data <= i_data;
            o_busy    <= 1'b1;
         end else begin
            o_busy <= req ^ ack_l;
         end
      end
   end

   // =====================================================================
   // core domain: edge of synced request gives a one-cycle valid
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         req_m   <= 1'b0;
         req_s   <= 1'b0;
         req_d   <= 1'b0;
         ack     <= 1'b0;
         o_valid <= 1'b0;
         o_code  <= 3'h0;
         o_data  <= 8'h00;
      end else begin
         req_m   <= req;
         req_s   <= req_m;
         req_d   <= req_s;
         ack     <= req_d;
         o_valid <= req_s ^ req_d;
         if (req_s ^ req_d) begin
            o_code <= hold_code;
            o_data <= hold_data;
         end
      end
   end
endmodule
`default_nettype wire

/* File: src/dpsa_arbiter.sv */
// ownership, latched status and alert logic for two management ports
`timescale 1ns/10ps
`default_nettype none
module dpsa_arbiter #(
   parameter int           FAULT_W   = 16,
   parameter logic [7:0]   BUS_START = dpsa_pkg::BUS_RESET
) (
   // core clock and reset
   input  wire logic               i_ref_clk,
   input  wire logic               i_rst,
   // link clock
   input  wire logic               i_link_clk,
   // mgmt_port_zero commands, link domain
   input  wire logic               i_mgmt_port_zero_strobe,
   input  wire logic [2:0]         i_mgmt_port_zero_code,
   input  wire logic [7:0]         i_mgmt_port_zero_data,
   output logic                    o_mgmt_port_zero_busy,
   // mgmt_port_one commands, link domain
   input  wire logic               i_mgmt_port_one_strobe,
   input  wire logic [2:0]         i_mgmt_port_one_code,
   input  wire logic [7:0]         i_mgmt_port_one_data,
   output logic                    o_mgmt_port_one_busy,
   // live unit conditions, asynchronous
   input  wire logic [FAULT_W-1:0] i_unit_fault,
   input  wire logic               i_iso_pass,
   input  wire logic               i_iso_fail,
   input  wire logic [7:0]         i_oper_state,
   // status seen by the ports
   output logic [7:0]              o_status_bus,
   output logic [15:0]             o_status_word,
   output logic [7:0]              o_status_cml,
   output logic [1:0]              o_iso_result,
   output logic [7:0]              o_oc_resp,
   output logic [7:0]              o_ot_resp,
   output logic [7:0]              o_oper_state,
   // open-drain alert pins
   output logic                    o_alert_zero_out,
   output logic                    o_alert_zero_oe_n,
   output logic                    o_alert_one_out,
   output logic                    o_alert_one_oe_n
);

   if (FAULT_W != dpsa_pkg::WORD_W) begin : g_bad_fault_w
      $error("fault width must match status word");
   end
   if (BUS_START != 8'h01 && BUS_START != 8'h10) begin : g_bad_start
      $error("start byte must name one owner");
   end

   // =====================================================================
   // crossings
   logic              cmd_valid [2];
   logic [2:0]        cmd_code  [2];
   logic [7:0]        cmd_data  [2];
   logic [15:0]       fault_live;
   logic [1:0]        iso_live;
   logic [7:0]        oper_live;

   dpsa_cmd_xing u_xing_zero (
      .i_link_clk (i_link_clk),
      .i_strobe   (i_mgmt_port_zero_strobe),
      .i_code     (i_mgmt_port_zero_code),
      .i_data     (i_mgmt_port_zero_data),
      .o_busy     (o_mgmt_port_zero_busy),
      .i_ref_clk  (i_ref_clk),
      .i_rst      (i_rst),
      .o_valid    (cmd_valid[0]),
      .o_code     (cmd_code[0]),
      .o_data     (cmd_data[0])
   );

   dpsa_cmd_xing u_xing_one (
      .i_link_clk (i_link_clk),
      .i_strobe   (i_mgmt_port_one_strobe),
      .i_code     (i_mgmt_port_one_code),
      .i_data     (i_mgmt_port_one_data),
      .o_busy     (o_mgmt_port_one_busy),
      .i_ref_clk  (i_ref_clk),
      .i_rst      (i_rst),
      .o_valid    (cmd_valid[1]),
      .o_code     (cmd_code[1]),
      .o_data     (cmd_data[1])
   );

   dpsa_sync2 #(.W(26)) u_sync_unit (
      .i_clk (i_ref_clk),
      .i_rst (i_rst),
      .i_d   ({i_unit_fault, i_iso_fail, i_iso_pass, i_oper_state}),
      .o_q   ({fault_live, iso_live, oper_live})
   );

   // =====================================================================
   // helpers
   function automatic logic [3:0] nib_of(input logic [7:0] b, input int p);
      nib_of = p == 0 ? b[3:0] : b[7:4];
   endfunction

   function automatic logic [7:0] nib_put(input logic [7:0] b, input int p,
                                          input logic [3:0] n);
      nib_put = p == 0 ? {b[7:4], n} : {n, b[3:0]};
   endfunction

   // =====================================================================
   // next-state: port zero handled before port one in a shared cycle,
   // so two commands in one cycle both take effect in that order
   logic [7:0]  next_bus;
   logic [15:0] next_word;
   logic [7:0]  next_cml;
   logic [1:0]  next_cml_own;
   logic [1:0]  next_iso;
   logic [7:0]  next_oc;
   logic [7:0]  next_ot;
   logic [1:0]  next_alert;
   logic [1:0]  cml_own;
   logic        unit_pending;

   always_comb begin
      logic ctl;
      logic rej;
      ctl          = 1'b0;
      rej          = 1'b0;
      next_bus     = o_status_bus;
      next_word    = o_status_word;
      next_cml     = o_status_cml;
      next_cml_own = cml_own;
      next_iso     = o_iso_result;
      next_oc      = o_oc_resp;
      next_ot      = o_ot_resp;
      for (int p = 0; p < 2; p++) begin
         ctl = |(nib_of(next_bus, p) & dpsa_pkg::NIB_CTL);
         rej = 1'b0;
         if (cmd_valid[p]) begin
            case (cmd_code[p])
               dpsa_pkg::DPSA_CMD_CLEAR: begin
                  // own notices held so far only; one raised this cycle wins
                  next_bus = nib_put(next_bus, p, nib_of(next_bus, p)
                             & ~(nib_of(o_status_bus, p) & dpsa_pkg::NIB_NOTICE));
                  if (ctl) begin
                     next_word    = dpsa_pkg::WORD_ZERO;
                     next_cml     = dpsa_pkg::BYTE_ZERO;
                     next_cml_own = 2'h0;
                     next_iso     = dpsa_pkg::ISO_ZERO;
                  end
               end
               dpsa_pkg::DPSA_CMD_TAKE: begin
                  if (!ctl) begin
                     next_bus = nib_put(next_bus, p,
                                        nib_of(next_bus, p) | dpsa_pkg::NIB_TAKE);
                     next_bus = nib_put(next_bus, 1 - p,
                                        (nib_of(next_bus, 1 - p) & ~dpsa_pkg::NIB_CTL)
                                        | dpsa_pkg::NIB_LOST);
                  end
               end
               dpsa_pkg::DPSA_CMD_BAD: begin
                  if (ctl) begin
                     next_word       = next_word | dpsa_pkg::WORD_CML;
                     next_cml        = next_cml | dpsa_pkg::CML_BAD;
                     next_cml_own[p] = 1'b1;
                  end else begin
                     rej = 1'b1;
                  end
               end
               dpsa_pkg::DPSA_CMD_SET_OC: begin
                  if (ctl) next_oc = cmd_data[p];
                  else rej = 1'b1;
               end
               dpsa_pkg::DPSA_CMD_SET_OT: begin
                  if (ctl) next_ot = cmd_data[p];
                  else rej = 1'b1;
               end
               dpsa_pkg::DPSA_CMD_WRITE: begin
                  rej = !ctl;
               end
               default: begin
                  // reads change nothing; status is read before clearing
                  rej = 1'b0;
               end
            endcase
            if (rej) begin
               next_bus = nib_put(next_bus, p,
                                  nib_of(next_bus, p) | dpsa_pkg::NIB_REJECT);
            end
         end
      end
      // live faults land after the clear, so a lasting fault sets again;
      // the comm bit is owned by the command path, not the fault pins
      next_word = next_word | (fault_live & ~dpsa_pkg::WORD_CML);
      next_iso  = next_iso | iso_live;
      unit_pending = |(next_word & ~dpsa_pkg::WORD_CML) || |next_iso;
      for (int p = 0; p < 2; p++) begin
         next_alert[p] = |(nib_of(next_bus, p) & dpsa_pkg::NIB_NOTICE)
                         || unit_pending || next_cml_own[p];
      end
   end

   // =====================================================================
   // ownership byte: unit faults never touch it
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) o_status_bus <= BUS_START;
      else o_status_bus <= next_bus;
   end

   // =====================================================================
   // latched unit status; no restarted bit is kept, latched bits say it
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_status_word <= dpsa_pkg::WORD_ZERO;
         o_status_cml  <= dpsa_pkg::BYTE_ZERO;
         cml_own       <= 2'h0;
         o_iso_result  <= dpsa_pkg::ISO_ZERO;
      end else begin
         o_status_word <= next_word;
         o_status_cml  <= next_cml;
         cml_own       <= next_cml_own;
         o_iso_result  <= next_iso;
      end
   end

   // =====================================================================
   // response settings, outside the reach of clear
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_oc_resp <= dpsa_pkg::BYTE_ZERO;
         o_ot_resp <= dpsa_pkg::BYTE_ZERO;
      end else begin
         o_oc_resp <= next_oc;
         o_ot_resp <= next_ot;
      end
   end

   // =====================================================================
   // operational state follows the live value, never latched;
   // held one cycle first: a multi-bit word may be caught mid-change
   logic [7:0] oper_prev;

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         oper_prev    <= dpsa_pkg::BYTE_ZERO;
         o_oper_state <= dpsa_pkg::BYTE_ZERO;
      end else begin
         oper_prev <= oper_live;
         if (oper_live == oper_prev) o_oper_state <= oper_live;
      end
   end

   // =====================================================================
   // alert pins: pulled up outside, so the block only ever sinks
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_alert_zero_out  <= 1'b0;
         o_alert_zero_oe_n <= 1'b1;
         o_alert_one_out   <= 1'b0;
         o_alert_one_oe_n  <= 1'b1;
      end else begin
         o_alert_zero_out  <= 1'b0;
         o_alert_zero_oe_n <= !next_alert[0];
         o_alert_one_out   <= 1'b0;
         o_alert_one_oe_n  <= !next_alert[1];
      end
   end

   // =====================================================================
   // checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   logic own0;
   logic own1;
   assign own0 = o_status_bus[0];
   assign own1 = o_status_bus[4];

   a_owner_clean_byte: assert property (
      (o_status_bus[3:1] == 3'h0 && o_status_bus[7:5] == 3'h0)
      |-> (o_status_bus == 8'h01 || o_status_bus == 8'h10))
      else $error("clean ownership byte not 0x01 or 0x10");

   a_reject_port_one: assert property (
      (cmd_valid[1] && cmd_code[1] == dpsa_pkg::DPSA_CMD_WRITE && own0 && !cmd_valid[0]
       && o_status_bus == 8'h01)
      |=> (o_status_bus == 8'hC1 && !o_alert_one_oe_n))
      else $error("port one refusal did not give 0xC1");

   a_reject_port_zero: assert property (
      (cmd_valid[0] && cmd_code[0] == dpsa_pkg::DPSA_CMD_WRITE && own1 && !cmd_valid[1]
       && o_status_bus == 8'h10)
      |=> (o_status_bus == 8'h1C && !o_alert_zero_oe_n))
      else $error("port zero refusal did not give 0x1C");

   a_foreign_clear: assert property (
      (cmd_valid[1] && cmd_code[1] == dpsa_pkg::DPSA_CMD_CLEAR && own0 && !cmd_valid[0]
       && fault_live == 16'h0000)
      |=> (o_status_bus[7:5] == 3'h0 && $stable(o_status_word) && $stable(o_status_bus[3:0])))
      else $error("non-owner clear touched more than its notice");

   a_fault_both_alert: assert property (
      (|(fault_live & ~dpsa_pkg::WORD_CML))
      |=> (!o_alert_zero_oe_n && !o_alert_one_oe_n && $stable(o_status_bus)) or
          $past(cmd_valid[0] || cmd_valid[1]))
      else $error("unit fault did not assert both alerts");

   a_take_port_one: assert property (
      (cmd_valid[1] && cmd_code[1] == dpsa_pkg::DPSA_CMD_TAKE && o_status_bus == 8'h01
       && !cmd_valid[0])
      |=> (o_status_bus == 8'h74 ##1 o_status_bus == 8'h74 || cmd_valid[0] || cmd_valid[1]))
      else $error("port one takeover did not give 0x74");

   a_take_port_zero: assert property (
      (cmd_valid[0] && cmd_code[0] == dpsa_pkg::DPSA_CMD_TAKE && o_status_bus == 8'h10
       && !cmd_valid[1])
      |=> (o_status_bus == 8'h47 && !o_alert_zero_oe_n && !o_alert_one_oe_n))
      else $error("port zero takeover did not give 0x47");

   a_bad_command: assert property (
      (cmd_valid[1] && cmd_code[1] == dpsa_pkg::DPSA_CMD_BAD && own1 && !cmd_valid[0])
      |=> (o_status_word[1] && o_status_cml == 8'h80 && !o_alert_one_oe_n))
      else $error("bad command not recorded");

   a_owner_clear: assert property (
      (cmd_valid[0] && cmd_code[0] == dpsa_pkg::DPSA_CMD_CLEAR && own0 && !cmd_valid[1]
       && fault_live == 16'h0000)
      |=> (o_status_word == 16'h0000 && o_status_cml == 8'h00 && o_status_bus[3:1] == 3'h0))
      else $error("owner clear left status behind");

   a_resp_kept: assert property (
      (!(cmd_valid[0] && cmd_code[0] == dpsa_pkg::DPSA_CMD_SET_OC) &&
       !(cmd_valid[1] && cmd_code[1] == dpsa_pkg::DPSA_CMD_SET_OC))
      |=> $stable(o_oc_resp))
      else $error("over-current response changed without command");

   a_alert_notice: assert property (
      (o_status_bus[7:5] != 3'h0) |-> (!o_alert_one_oe_n && o_alert_one_out == 1'b0))
      else $error("port one alert released with notice pending");

   a_take_keeps_word: assert property (
      (cmd_valid[1] && cmd_code[1] == dpsa_pkg::DPSA_CMD_TAKE && !cmd_valid[0])
      |=> ((o_status_word & $past(o_status_word)) == $past(o_status_word)))
      else $error("takeover dropped pending status word");

   a_oper_follows: assert property (
      (oper_live == oper_prev) |=> (o_oper_state == $past(oper_live)))
      else $error("operational state did not follow live value");

endmodule
`default_nettype wire

/* File: sim/dpsa_mgmt_ctrl.sv */
// link-side model of one management controller
`timescale 1ns/10ps
`default_nettype none
module dpsa_mgmt_ctrl (
   // link clock and handshake
   input  wire logic i_link_clk,
   input  wire logic i_busy,
   // command
   output logic       o_strobe,
   output logic [2:0] o_code,
   output logic [7:0] o_data
);
   // =====================================================================
   // idle
   initial begin
      o_strobe = 1'b0;
      o_code   = 3'h0;
      o_data   = 8'h00;
   end

   // =====================================================================
   // one command, then wait out busy; ok stays low if busy never cycles
   task automatic issue(input logic [2:0] c, input logic [7:0] d, output logic ok);
      logic hi;
      int   n;
      ok = 1'b0;
      hi = 1'b0;
      @(negedge i_link_clk);
      o_strobe = 1'b1;
      o_code   = c;
      o_data   = d;
      @(negedge i_link_clk);
      o_strobe = 1'b0;
      // stale code and data never look like the last command
      o_code   = ~c;
      o_data   = ~d;
      for (n = 0; n < 40 && !ok; n++) begin
         hi = hi | i_busy;
         @(negedge i_link_clk);
         ok = hi && !i_busy;
      end
   endtask
endmodule
`default_nettype wire

/* File: sim/tb_dual_port_status_arbiter.sv */
// self-checking bench for the dual-port status arbiter
`timescale 1ns/10ps
`default_nettype none
module tb_dual_port_status_arbiter;
   localparam logic [2:0] C_RD  = dpsa_pkg::DPSA_CMD_READ;
   localparam logic [2:0] C_WR  = dpsa_pkg::DPSA_CMD_WRITE;
   localparam logic [2:0] C_CLR = dpsa_pkg::DPSA_CMD_CLEAR;
   localparam logic [2:0] C_BAD = dpsa_pkg::DPSA_CMD_BAD;
   localparam logic [2:0] C_TK  = dpsa_pkg::DPSA_CMD_TAKE;
   localparam logic [2:0] C_OC  = dpsa_pkg::DPSA_CMD_SET_OC;
   localparam logic [2:0] C_OT  = dpsa_pkg::DPSA_CMD_SET_OT;
   logic        ref_clk, rst, link_clk, stb0, stb1, busy0, busy1, iso_pass, iso_fail;
   logic [2:0]  code0, code1;
   logic [7:0]  data0, data1, oper_in, status_bus, status_cml, oc_resp, ot_resp, oper_out;
   logic [15:0] unit_fault, status_word;
   logic [1:0]  iso_result;
   logic        a0_out, a0_oe_n, a1_out, a1_oe_n;
   int          err_total, compares;
   // pulled-up open-drain lines
   wire         alert0_line = a0_oe_n ? 1'b1 : a0_out;
   wire         alert1_line = a1_oe_n ? 1'b1 : a1_out;

   // =====================================================================
   // design and the two controllers
   dpsa_arbiter i_dpsa_arbiter (.i_ref_clk(ref_clk), .i_rst(rst), .i_link_clk(link_clk),
      .i_mgmt_port_zero_strobe(stb0), .i_mgmt_port_zero_code(code0),
      .i_mgmt_port_zero_data(data0), .o_mgmt_port_zero_busy(busy0),
      .i_mgmt_port_one_strobe(stb1), .i_mgmt_port_one_code(code1),
      .i_mgmt_port_one_data(data1), .o_mgmt_port_one_busy(busy1),
      .i_unit_fault(unit_fault), .i_iso_pass(iso_pass), .i_iso_fail(iso_fail),
      .i_oper_state(oper_in), .o_status_bus(status_bus), .o_status_word(status_word),
      .o_status_cml(status_cml), .o_iso_result(iso_result), .o_oc_resp(oc_resp),
      .o_ot_resp(ot_resp), .o_oper_state(oper_out), .o_alert_zero_out(a0_out),
      .o_alert_zero_oe_n(a0_oe_n), .o_alert_one_out(a1_out), .o_alert_one_oe_n(a1_oe_n));
   dpsa_mgmt_ctrl i_dpsa_mgmt_ctrl_zero (.i_link_clk(link_clk), .i_busy(busy0),
      .o_strobe(stb0), .o_code(code0), .o_data(data0));
   dpsa_mgmt_ctrl i_dpsa_mgmt_ctrl_one (.i_link_clk(link_clk), .i_busy(busy1),
      .o_strobe(stb1), .o_code(code1), .o_data(data1));

   // =====================================================================
   // clocks, link clock offset so the two never line up
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   initial begin
      link_clk = 1'b0;
      #3.7;
      forever #16 link_clk = ~link_clk;
   end

   // =====================================================================
   // shared checks
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic settle;
      repeat (8) @(negedge ref_clk);
   endtask
   task automatic look(input logic [7:0] bus, input logic [1:0] alr, input logic [15:0] word,
                       input logic [7:0] cml);
      chk("status_bus", {8'h00, bus}, {8'h00, status_bus});
      chk("alerts", {14'h0000, alr}, {14'h0000, ~alert1_line, ~alert0_line});
      chk("status_word", word, status_word);
      chk("status_cml", {8'h00, cml}, {8'h00, status_cml});
   endtask
   task automatic step(input logic port, input logic [2:0] c, input logic [7:0] d,
                       input logic [7:0] bus, input logic [1:0] alr, input logic [15:0] word,
                       input logic [7:0] cml);
      logic ok;
      if (port) begin
         i_dpsa_mgmt_ctrl_one.issue(c, d, ok);
      end else begin
         i_dpsa_mgmt_ctrl_zero.issue(c, d, ok);
      end
      chk("handshake", 16'h0001, {15'h0000, ok});
      settle();
      look(bus, alr, word, cml);
   endtask

   // =====================================================================
   // scenarios
   task automatic t_reject_one;
      step(1'b1, C_WR, 8'h00, 8'hC1, 2'b10, 16'h0000, 8'h00);
      step(1'b1, C_CLR, 8'h00, 8'h01, 2'b00, 16'h0000, 8'h00);
   endtask
   task automatic t_fault_takeover;
      unit_fault = 16'h0001;
      settle();
      look(8'h01, 2'b11, 16'h0001, 8'h00);
      step(1'b1, C_TK, 8'h00, 8'h74, 2'b11, 16'h0001, 8'h00);
      step(1'b1, C_RD, 8'h00, 8'h74, 2'b11, 16'h0001, 8'h00);
      unit_fault = 16'h0000;
      settle();
      look(8'h74, 2'b11, 16'h0001, 8'h00);
      step(1'b1, C_CLR, 8'h00, 8'h14, 2'b01, 16'h0000, 8'h00);
      step(1'b0, C_RD, 8'h00, 8'h14, 2'b01, 16'h0000, 8'h00);
      step(1'b0, C_CLR, 8'h00, 8'h10, 2'b00, 16'h0000, 8'h00);
   endtask
   task automatic t_sticky;
      unit_fault = 16'h0004;
      settle();
      unit_fault = 16'h0000;
      step(1'b0, C_CLR, 8'h00, 8'h10, 2'b11, 16'h0004, 8'h00);
      step(1'b1, C_CLR, 8'h00, 8'h10, 2'b00, 16'h0000, 8'h00);
      unit_fault = 16'h0008;
      step(1'b1, C_CLR, 8'h00, 8'h10, 2'b11, 16'h0008, 8'h00);
      unit_fault = 16'h0000;
      step(1'b1, C_CLR, 8'h00, 8'h10, 2'b00, 16'h0000, 8'h00);
      oper_in = 8'hA5;
      settle();
      chk("oper_state", 16'h00A5, {8'h00, oper_out});
      oper_in = 8'h00;
      settle();
      chk("oper_state", 16'h0000, {8'h00, oper_out});
   endtask
   task automatic t_iso_resp;
      iso_pass = 1'b1;
      settle();
      iso_pass = 1'b0;
      settle();
      chk("iso_result", 16'h0001, {14'h0000, iso_result});
      iso_fail = 1'b1;
      settle();
      iso_fail = 1'b0;
      step(1'b1, C_OC, 8'h5A, 8'h10, 2'b11, 16'h0000, 8'h00);
      chk("iso_result", 16'h0003, {14'h0000, iso_result});
      step(1'b1, C_OT, 8'h3C, 8'h10, 2'b11, 16'h0000, 8'h00);
      step(1'b1, C_CLR, 8'h00, 8'h10, 2'b00, 16'h0000, 8'h00);
      chk("iso_result", 16'h0000, {14'h0000, iso_result});
      chk("oc_resp", 16'h005A, {8'h00, oc_resp});
      chk("ot_resp", 16'h003C, {8'h00, ot_resp});
   endtask
   task automatic t_take_zero;
      step(1'b1, C_BAD, 8'h00, 8'h10, 2'b10, 16'h0002, 8'h80);
      step(1'b1, C_CLR, 8'h00, 8'h10, 2'b00, 16'h0000, 8'h00);
      step(1'b0, C_TK, 8'h00, 8'h47, 2'b11, 16'h0000, 8'h00);
      step(1'b0, C_CLR, 8'h00, 8'h41, 2'b10, 16'h0000, 8'h00);
      step(1'b1, C_CLR, 8'h00, 8'h01, 2'b00, 16'h0000, 8'h00);
   endtask
   task automatic t_reject_zero;
      step(1'b1, C_TK, 8'h00, 8'h74, 2'b11, 16'h0000, 8'h00);
      step(1'b1, C_CLR, 8'h00, 8'h14, 2'b01, 16'h0000, 8'h00);
      step(1'b0, C_CLR, 8'h00, 8'h10, 2'b00, 16'h0000, 8'h00);
      step(1'b0, C_WR, 8'h00, 8'h1C, 2'b01, 16'h0000, 8'h00);
      step(1'b0, C_OC, 8'h99, 8'h1C, 2'b01, 16'h0000, 8'h00);
      chk("oc_resp", 16'h005A, {8'h00, oc_resp});
      step(1'b0, C_CLR, 8'h00, 8'h10, 2'b00, 16'h0000, 8'h00);
   endtask

   // =====================================================================
   // verdict, reached from the main sequence or the watchdog
   task automatic wrap_up;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #100000;
      err_total++;
      wrap_up();
   end

   // =====================================================================
   // main sequence; reset spans enough link edges for its synchroniser
   initial begin
      err_total  = 0;
      compares   = 0;
      rst        = 1'b1;
      unit_fault = 16'h0000;
      iso_pass   = 1'b0;
      iso_fail   = 1'b0;
      oper_in    = 8'h00;
      repeat (5) @(negedge link_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      repeat (4) @(negedge link_clk);
      @(negedge ref_clk);
      look(8'h01, 2'b00, 16'h0000, 8'h00);
      t_reject_one();
      t_fault_takeover();
      t_sticky();
      t_iso_resp();
      t_take_zero();
      t_reject_zero();
      wrap_up();
   end
endmodule
`default_nettype wire
